//--- rtl/ring_line_ctl.sv
// Line-side ring detection and line interface control with APB registers
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ring_line_ctl (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ringSensePos,
    input wire logic [1:0] ringSenseNeg,
    input wire logic [4:0] lineSenseCode,
    output ring_line_pkg::line_drive_s lineDrive,
    output logic [15:0] sampleData,
    output logic sampleValid
);
    import ring_line_pkg::*;

    typedef struct packed {
        control_s control;
        logic [1:0] posMeta;
        logic [1:0] posSync;
        logic [1:0] negMeta;
        logic [1:0] negSync;
        logic ringPosFlag;
        logic ringNegFlag;
        logic ringDetectOneshot;
        logic [16:0] oneshotCount;
        logic [7:0] loopLevel;
        logic [15:0] sample;
        logic sampleValid;
        line_drive_s drive;
        logic [31:0] readData;
        logic ready;
        logic error;
    } state_s;

    state_s state;
    state_s next_state;
    logic tick;
    logic posAbove;
    logic negBelow;
    logic writeHit;
    logic [15:0] nextSample;

    sample_tick divider (
        .clock(clock),
        .reset(reset),
        .tick(tick)
    );

    // ==========================================
    // Threshold comparators, after synchronization
    always_comb begin
        posAbove = state.control.ringThresholdSelect ? state.posSync[1] : state.posSync[0];
        negBelow = state.control.ringThresholdSelect ? state.negSync[1] : state.negSync[0];
        writeHit = psel && penable && pwrite && !state.ready;
    end

    // ==========================================
    // Sample code
    always_comb begin
        if (state.control.ringFullWaveEnable) begin
            if (posAbove) begin
                nextSample = SAMPLE_MAX;
            end else if (negBelow) begin
                nextSample = SAMPLE_MIN;
            end else begin
                nextSample = SAMPLE_IDLE_FULL;
            end
        end else begin
            nextSample = posAbove ? SAMPLE_MAX : SAMPLE_MIN;
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.sampleValid = 1'b0;
        next_state.posMeta = ringSensePos;
        next_state.posSync = state.posMeta;
        next_state.negMeta = ringSenseNeg;
        next_state.negSync = state.negMeta;

        // APB slave: one wait state, answer in the second access cycle
        next_state.ready = 1'b0;
        next_state.error = 1'b0;
        if (psel && penable && !state.ready) begin
            next_state.ready = 1'b1;
            next_state.readData = 32'h0000_0000;
            case (paddr)
                CONTROL_OFFSET: begin
                    next_state.readData = {19'h0_0000, state.control};
                end
                STATUS_OFFSET: begin
                    next_state.readData = {29'h0000_0000, state.ringDetectOneshot,
                        state.ringNegFlag, state.ringPosFlag};
                end
                SENSE_OFFSET: begin
                    next_state.readData = {27'h000_0000, lineSenseCode};
                end
                SAMPLE_OFFSET: begin
                    next_state.readData = {16'h0000, state.sample};
                end
                default: begin
                    next_state.error = 1'b1;
                end
            endcase
            if (writeHit && paddr == CONTROL_OFFSET) begin
                next_state.control = control_s'(pwdata[CONTROL_WIDTH-1:0]);
            end
        end

        // Per-sample ring evaluation
        if (tick) begin
            next_state.ringPosFlag = posAbove;
            next_state.ringNegFlag = negBelow && !posAbove;
            if (posAbove && !state.ringPosFlag) begin
                next_state.ringDetectOneshot = 1'b1;
                next_state.oneshotCount = ONESHOT_SAMPLES;
            end else if (state.oneshotCount != 17'h0_0000) begin
                next_state.oneshotCount = state.oneshotCount - 17'h0_0001;
                if (state.oneshotCount == 17'h0_0001) begin
                    next_state.ringDetectOneshot = 1'b0;
                end
            end
            if (!state.control.linkPowerDown && !state.control.hookStateControl
                    && !state.control.onhookMonitorEnable) begin
                next_state.sample = nextSample;
                next_state.sampleValid = 1'b1;
            end
            // Loop current ramp
            if (state.control.hookStateControl) begin
                next_state.loopLevel = RAMP_STEPS;
            end else if (state.control.onhookSlowRamp && state.loopLevel != 8'h00) begin
                next_state.loopLevel = state.loopLevel - 8'h01;
            end
        end
        if (!state.control.hookStateControl && !state.control.onhookSlowRamp) begin
            next_state.loopLevel = 8'h00;
        end
        if (state.control.hookStateControl && !state.drive.offHook) begin
            next_state.ringDetectOneshot = 1'b0;
            next_state.oneshotCount = 17'h0_0000;
        end

        // Line drive outputs
        next_state.drive.complexAc = state.control.acImpedanceSelect;
        next_state.drive.synthRinger = state.control.ringerImpedanceSynth;
        next_state.drive.headroomBoost = state.control.toneHeadroomBoost;
        next_state.drive.dcMode = state.control.dcTermination;
        next_state.drive.txAttenuate17 = state.control.dcTermination == DC_JAPAN;
        next_state.drive.txAttenuate40 = state.control.dcTermination == DC_LOW_VOLTAGE;
        next_state.drive.japanLoop = state.control.dcTermination == DC_JAPAN
            || (state.control.dcTermination == DC_FCC
                && state.control.fccJapanLikeVariant);
        next_state.drive.lowVoltageLoop = state.control.dcTermination == DC_LOW_VOLTAGE
            || (state.control.dcTermination == DC_FCC
                && state.control.fccLowestVoltageVariant);
        next_state.drive.offHook = state.control.hookStateControl;
        next_state.drive.loopCurrentLevel = state.loopLevel;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.control <= control_s'(CONTROL_RESET);
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.readData;
    assign pready = state.ready;
    assign pslverr = state.error;
    assign lineDrive = state.drive;
    assign sampleData = state.sample;
    assign sampleValid = state.sampleValid;

    // ==========================================
    // Checks
    oneshot_offhook_a: assert property (@(posedge clock) disable iff (reset)
        $rose(state.control.hookStateControl) |=> !state.ringDetectOneshot)
        else $error("one-shot not cleared on off-hook");
    flags_exclusive_a: assert property (@(posedge clock) disable iff (reset)
        !(state.ringPosFlag && state.ringNegFlag))
        else $error("both ring flags set");
    posflag_follow_a: assert property (@(posedge clock) disable iff (reset)
        tick |=> state.ringPosFlag == $past(posAbove))
        else $error("positive flag wrong");
    negflag_follow_a: assert property (@(posedge clock) disable iff (reset)
        tick && negBelow && !posAbove |=> state.ringNegFlag)
        else $error("negative flag wrong");
    oneshot_set_a: assert property (@(posedge clock) disable iff (reset)
        tick && posAbove && !state.ringPosFlag && !state.control.hookStateControl
        |=> state.ringDetectOneshot && state.oneshotCount == 17'h1_0000)
        else $error("one-shot not armed");
    oneshot_expire_a: assert property (@(posedge clock) disable iff (reset)
        $fell(state.ringDetectOneshot) |-> state.oneshotCount == 17'h0_0000)
        else $error("one-shot ended early");
    stream_gate_a: assert property (@(posedge clock) disable iff (reset)
        state.sampleValid |-> !$past(state.control.linkPowerDown)
            && !$past(state.control.hookStateControl))
        else $error("sample sent while gated");
    halfwave_code_a: assert property (@(posedge clock) disable iff (reset)
        state.sampleValid && !$past(state.control.ringFullWaveEnable)
        |-> state.sample == SAMPLE_MAX || state.sample == SAMPLE_MIN)
        else $error("bad half-wave code");
    fcc_variant_a: assert property (@(posedge clock) disable iff (reset)
        state.drive.japanLoop && state.drive.dcMode == DC_FCC |-> !state.drive.txAttenuate17)
        else $error("variant attenuates");

endmodule : ring_line_ctl
`default_nettype wire

//--- rtl/ring_line_pkg.sv
// Package: register map, field layout, reset values, timing and carriers for the line interface
package ring_line_pkg;

    // ==========================================
    // APB register offsets
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SENSE_OFFSET = 8'h08;
    localparam logic [7:0] SAMPLE_OFFSET = 8'h0C;

    // ==========================================
    // Control register field positions
    localparam int AC_IMPEDANCE_BIT = 0;
    localparam int FULL_WAVE_BIT = 1;
    localparam int THRESHOLD_BIT = 2;
    localparam int HOOK_BIT = 3;
    localparam int MONITOR_BIT = 4;
    localparam int POWER_DOWN_BIT = 5;
    localparam int RINGER_SYNTH_BIT = 6;
    localparam int HEADROOM_BIT = 7;
    localparam int JAPAN_VARIANT_BIT = 8;
    localparam int LOW_VARIANT_BIT = 9;
    localparam int SLOW_RAMP_BIT = 10;
    localparam int DC_TERM_LSB = 11;
    localparam int CONTROL_WIDTH = 13;

    // Status register field positions
    localparam int POS_FLAG_BIT = 0;
    localparam int NEG_FLAG_BIT = 1;
    localparam int ONESHOT_BIT = 2;

    // Reset value of control: FCC dc termination, link powered down
    localparam logic [12:0] CONTROL_RESET = 13'h1020;

    // ==========================================
    // Dc termination codes
    localparam logic [1:0] DC_LOW_VOLTAGE = 2'b00;
    localparam logic [1:0] DC_JAPAN = 2'b01;
    localparam logic [1:0] DC_FCC = 2'b10;
    localparam logic [1:0] DC_CTR21 = 2'b11;

    // ==========================================
    // Serial sample codes
    localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;
    localparam logic [15:0] SAMPLE_MIN = 16'h8000;
    localparam logic [15:0] SAMPLE_IDLE_FULL = 16'h04CC;

    // ==========================================
    // Timing
    localparam int CLOCK_HZ = 125_000_000;
    localparam int SAMPLE_RATE_HZ = 8000;
    localparam int SAMPLE_DIVIDE = CLOCK_HZ / SAMPLE_RATE_HZ;
    localparam logic [16:0] ONESHOT_SAMPLES = 17'h1_0000;
    localparam logic [7:0] RAMP_STEPS = 8'hFF;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic [1:0] dcTermination;
        logic onhookSlowRamp;
        logic fccLowestVoltageVariant;
        logic fccJapanLikeVariant;
        logic toneHeadroomBoost;
        logic ringerImpedanceSynth;
        logic linkPowerDown;
        logic onhookMonitorEnable;
        logic hookStateControl;
        logic ringThresholdSelect;
        logic ringFullWaveEnable;
        logic acImpedanceSelect;
    } control_s;

    typedef struct packed {
        logic complexAc;
        logic synthRinger;
        logic headroomBoost;
        logic txAttenuate17;
        logic txAttenuate40;
        logic japanLoop;
        logic lowVoltageLoop;
        logic [1:0] dcMode;
        logic offHook;
        logic [7:0] loopCurrentLevel;
    } line_drive_s;

endpackage : ring_line_pkg

//--- rtl/sample_tick.sv
// Sample-rate enable divider
`timescale 1ns/1ns
`default_nettype none
module sample_tick (
    input wire logic clock,
    input wire logic reset,
    output logic tick
);
    import ring_line_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } state_s;

    state_s state;
    state_s next_state;

    // ==========================================
    // Divider
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count == 16'(SAMPLE_DIVIDE - 1)) begin
            next_state.count = 16'h0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : sample_tick
`default_nettype wire

//--- sim/host_sample_sink.sv
// Host-side sink for the ring sample stream
`timescale 1ns/1ns
`default_nettype none
module host_sample_sink (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] sampleData,
    input wire logic sampleValid,
    output logic [7:0] sampleCount,
    output logic [7:0] msbToggles
);
    logic lastMsb;
    // ==========================================
    // Sample count and sign-bit cadence
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sampleCount <= 8'h00;
            msbToggles <= 8'h00;
            lastMsb <= 1'b0;
        end else if (sampleValid) begin
            sampleCount <= sampleCount + 8'h01;
            if (sampleData[15] != lastMsb) begin
                msbToggles <= msbToggles + 8'h01;
            end
            lastMsb <= sampleData[15];
        end
    end
endmodule : host_sample_sink
`default_nettype wire

//--- sim/ring_line_ctl_tb.sv
// Self-checking testbench for the ring line controller
`timescale 1ns/1ns
`default_nettype none
module ring_line_ctl_tb;
    import ring_line_pkg::*;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, sampleValid;
    logic [7:0] paddr, sampleCount, msbToggles;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ringSensePos, ringSenseNeg;
    logic [4:0] lineSenseCode;
    logic [15:0] sampleData;
    line_drive_s lineDrive, e;
    logic [15:0] expQ[$];
    logic [12:0] ctlTab[4] = '{13'h1000, 13'h1000, 13'h1006, 13'h1006};
    logic [1:0] posTab[4] = '{2'b00, 2'b01, 2'b01, 2'b00};
    logic [1:0] negTab[4] = '{2'b01, 2'b00, 2'b00, 2'b10};
    logic [15:0] smpTab[4] = '{16'h8000, 16'h7FFF, 16'h04CC, 16'h8000};
    logic [31:0] statTab[4] = '{32'h0000_0002, 32'h0000_0005, 32'h0000_0004, 32'h0000_0006};
    logic [31:0] r;
    logic err;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int i;
    ring_line_ctl i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ringSensePos(ringSensePos), .ringSenseNeg(ringSenseNeg),
        .lineSenseCode(lineSenseCode), .lineDrive(lineDrive), .sampleData(sampleData),
        .sampleValid(sampleValid));
    host_sample_sink i_host (.clock(clock), .reset(reset), .sampleData(sampleData),
        .sampleValid(sampleValid), .sampleCount(sampleCount), .msbToggles(msbToggles));
    // ==========================================
    // Clock, timeout and shared tasks
    always #4 clock = ~clock;
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clock) begin
        cycles++;
        if (cycles == 99000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic wait_sample();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (sampleValid !== 1'b1 && n < 20000);
    endtask : wait_sample
    // ==========================================
    // Sample monitor
    always @(posedge clock) begin
        if (sampleValid === 1'b1 && expQ.size() > 0) begin
            check("sample", {16'h0000, sampleData}, {16'h0000, expQ.pop_front()});
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ringSensePos, ringSenseNeg, lineSenseCode} = '0;
        void'($urandom(32'hda32));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        lineSenseCode <= 5'($urandom);
        repeat (3) @(posedge clock);
        apb(1'b0, CONTROL_OFFSET, 32'h0000_0000);
        check("control reset", rd, {19'h0_0000, CONTROL_RESET});
        check("dc mode", {30'h0000_0000, lineDrive.dcMode}, {30'h0000_0000, DC_FCC});
        apb(1'b0, SENSE_OFFSET, 32'h0000_0000);
        check("sense code", rd, {27'h000_0000, lineSenseCode});
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            r[1] = r[1] && (i == 3) && (lineSenseCode < 5'd12);
            apb(1'b1, CONTROL_OFFSET, {19'h0_0000, 2'(i), 1'b0, r[3:0], 1'b1, 4'h0, r[4]});
            repeat (3) @(posedge clock);
            e = '0;
            e.complexAc = r[4];
            e.synthRinger = r[0];
            e.headroomBoost = r[1];
            e.txAttenuate17 = (i == 1);
            e.txAttenuate40 = (i == 0);
            e.japanLoop = (i == 1) || (i == 2 && r[2]);
            e.lowVoltageLoop = (i == 0) || (i == 2 && r[3]);
            e.dcMode = 2'(i);
            check("line drive", 32'(lineDrive), 32'(e));
        end
        apb(1'b1, CONTROL_OFFSET, 32'h0000_0820);
        repeat (3) @(posedge clock);
        check("attenuation back", {31'h0000_0000, lineDrive.txAttenuate17}, 32'h0000_0001);
        apb(1'b1, CONTROL_OFFSET, 32'h0000_1000);
        wait_sample();
        for (i = 0; i < 4; i++) begin
            apb(1'b1, CONTROL_OFFSET, {19'h0_0000, ctlTab[i]});
            ringSensePos <= posTab[i];
            ringSenseNeg <= negTab[i];
            expQ.push_back(smpTab[i]);
            wait_sample();
            apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
            check("status", rd, statTab[i]);
        end
        apb(1'b1, CONTROL_OFFSET, 32'h0000_1408);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        check("oneshot", {31'h0000_0000, rd[2]}, 32'h0000_0000);
        check("off hook", {31'h0000_0000, lineDrive.offHook}, 32'h0000_0001);
        repeat (16000) @(posedge clock);
        apb(1'b1, CONTROL_OFFSET, 32'h0000_1400);
        repeat (3) @(posedge clock);
        check("ramp level", {25'h000_0000, lineDrive.loopCurrentLevel[7:1]}, 32'h0000_007F);
        check("sample count", {24'h00_0000, sampleCount}, 32'h0000_0005);
        check("sign toggles", {24'h00_0000, msbToggles}, 32'h0000_0003);
        end_sim();
    end
endmodule : ring_line_ctl_tb
`default_nettype wire
